// >>> qbl_boot_loader.sv
// quad flash boot loader: strap decode, flash read master, image stream
// assumes the flash lanes are pins, asynchronous to core_clk, and that
// the image sink on image_* runs on core_clk
`timescale 1ns/1ps
`default_nettype none
module qbl_boot_loader
  import qbl_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  // flash link
  output logic flash_cs_n,
  output logic flash_sclk,
  input wire logic flash_lane0_i,
  output logic flash_lane0_o,
  output logic flash_lane0_oe_n,
  input wire logic flash_lane1_boot_strap_i,
  output logic flash_lane1_boot_strap_o,
  output logic flash_lane1_boot_strap_oe_n,
  input wire logic flash_lane2_i,
  output logic flash_lane2_o,
  output logic flash_lane2_oe_n,
  input wire logic flash_lane3_i,
  output logic flash_lane3_o,
  output logic flash_lane3_oe_n,
  // boot mode status
  output logic boot_flash_mode,
  output logic boot_slave_mode,
  output logic load_done,
  // image stream and stop request
  input wire logic load_stop,
  output logic image_valid,
  input wire logic image_ready,
  output logic [7:0] image_data
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] lanes_s;

  qbl_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(core_clk),
    .rst_n(reset_n),
    .async_in({flash_lane3_i, flash_lane2_i, flash_lane1_boot_strap_i, flash_lane0_i}),
    .sync_out(lanes_s)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  qbl_state_t state_q;
  logic [4:0] settle_q;
  logic [3:0] div_q;
  logic tick;
  logic run;
  logic fall;
  logic rise;
  logic [5:0] cnt_q;
  logic [31:0] shift_q;
  logic nib_q;
  logic [3:0] low_nib_q;
  logic byte_pend_q;
  logic [7:0] byte_q;
  logic fifo_in_ready;

  // the flash clock pauses low at a byte boundary while a byte waits;
  // select stays low, so the flash simply holds its read position
  assign run = (state_q == QBL_ST_HDR) || (state_q == QBL_ST_DUMMY) ||
               ((state_q == QBL_ST_DATA) && !(byte_pend_q && !flash_sclk && !nib_q)); // RULE10
  assign tick = run && (div_q == QBL_SCLK_HALF - 4'h1);
  assign fall = tick && flash_sclk;
  assign rise = tick && !flash_sclk;

  // ****************************************************************
  // clock divider
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 4'h0;
    end else if (!run || tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_sclk <= 1'b0;
    end else if (tick) begin
      flash_sclk <= !flash_sclk; // RULE1
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // nothing moves until reset_n is released; the strap is read once the
  // synchroniser has settled and before lane1 is used for data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= QBL_ST_STRAP; // RULE9
      settle_q <= 5'h00;
      cnt_q <= 6'h00;
    end else begin
      case (state_q)
        QBL_ST_STRAP: begin
          if (settle_q == QBL_STRAP_CYCLES) begin
            if (lanes_s[1]) begin // RULE5
              state_q <= QBL_ST_SLAVE; // RULE3
            end else begin
              state_q <= QBL_ST_HDR; // RULE4
            end
          end else begin
            settle_q <= settle_q + 5'h01;
          end
        end
        QBL_ST_SLAVE: begin
          state_q <= QBL_ST_SLAVE;
        end
        QBL_ST_HDR: begin
          if (fall) begin
            if (cnt_q == QBL_HDR_BITS - 6'h01) begin
              cnt_q <= 6'h00;
              state_q <= QBL_ST_DUMMY;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
        end
        QBL_ST_DUMMY: begin
          if (fall) begin
            if (cnt_q == QBL_DUMMY_CLKS - 6'h01) begin
              cnt_q <= 6'h00;
              state_q <= QBL_ST_DATA;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
        end
        QBL_ST_DATA: begin
          // stop only on a whole byte so no half byte is lost
          if (fall && nib_q && load_stop) begin
            state_q <= QBL_ST_DONE;
          end
        end
        QBL_ST_DONE: begin
          state_q <= QBL_ST_DONE;
        end
        default: begin
          state_q <= QBL_ST_STRAP;
        end
      endcase
    end
  end

  // ****************************************************************
  // command and address shifter
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 32'h00000000;
    end else if (state_q == QBL_ST_STRAP) begin
      shift_q <= {QBL_READ_CMD, QBL_START_ADDR}; // RULE2
    end else if (state_q == QBL_ST_HDR && fall) begin
      shift_q <= {shift_q[30:0], 1'b0};
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // lane0 carries the header msb first; lanes 2 and 3 are held high
  // then so write-protect and hold stay inactive; all lanes released
  // in the data phase and in slave boot
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cs_n <= 1'b1;
      flash_lane0_o <= 1'b0;
      flash_lane0_oe_n <= 1'b1;
      flash_lane1_boot_strap_o <= 1'b0;
      flash_lane1_boot_strap_oe_n <= 1'b1;
      flash_lane2_o <= 1'b1;
      flash_lane2_oe_n <= 1'b1;
      flash_lane3_o <= 1'b1;
      flash_lane3_oe_n <= 1'b1;
    end else begin
      flash_cs_n <= !((state_q == QBL_ST_HDR) || (state_q == QBL_ST_DUMMY) ||
                      (state_q == QBL_ST_DATA)); // RULE10
      flash_lane0_o <= shift_q[31]; // RULE2
      flash_lane0_oe_n <= (state_q != QBL_ST_HDR); // RULE1
      flash_lane1_boot_strap_o <= 1'b0;
      flash_lane1_boot_strap_oe_n <= 1'b1; // RULE3
      flash_lane2_o <= 1'b1;
      flash_lane2_oe_n <= (state_q != QBL_ST_HDR);
      flash_lane3_o <= 1'b1;
      flash_lane3_oe_n <= (state_q != QBL_ST_HDR);
    end
  end

  // ****************************************************************
  // nibble capture
  // ****************************************************************
  // sampled at the end of the high phase: the nibble launched on the
  // previous falling edge has had a full period, sync delay included
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nib_q <= 1'b0;
      low_nib_q <= 4'h0;
      byte_q <= 8'h00;
      byte_pend_q <= 1'b0;
    end else begin
      if (state_q == QBL_ST_DATA && fall) begin
        nib_q <= !nib_q;
        if (!nib_q) begin
          low_nib_q <= lanes_s; // RULE6
        end else begin
          byte_q <= {lanes_s, low_nib_q}; // RULE6
          byte_pend_q <= 1'b1;
        end
      end else if (byte_pend_q && fifo_in_ready) begin
        byte_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // status
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_flash_mode <= 1'b0;
      boot_slave_mode <= 1'b0;
      load_done <= 1'b0;
    end else begin
      boot_flash_mode <= (state_q == QBL_ST_HDR) || (state_q == QBL_ST_DUMMY) ||
                         (state_q == QBL_ST_DATA) || (state_q == QBL_ST_DONE);
      boot_slave_mode <= (state_q == QBL_ST_SLAVE);
      load_done <= (state_q == QBL_ST_DONE) && !byte_pend_q;
    end
  end

  // ****************************************************************
  // image buffer
  // ****************************************************************
  qbl_fifo #(
    .WIDTH(QBL_FIFO_WIDTH),
    .DEPTH(QBL_FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(reset_n),
    .in_valid(byte_pend_q),
    .in_ready(fifo_in_ready),
    .in_data(byte_q),
    .out_valid(image_valid),
    .out_ready(image_ready),
    .out_data(image_data)
  );

endmodule
`default_nettype wire

// >>> qbl_boot_loader_checker.sv
// assertions on the boot loader's flash and status ports
// assumes it is bound into qbl_boot_loader, one clock domain
`timescale 1ns/1ps
`default_nettype none
module qbl_boot_loader_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic flash_cs_n,
  input wire logic flash_sclk,
  input wire logic flash_lane0_o,
  input wire logic flash_lane0_oe_n,
  input wire logic flash_lane1_boot_strap_oe_n,
  input wire logic flash_lane2_oe_n,
  input wire logic flash_lane3_oe_n,
  input wire logic boot_flash_mode,
  input wire logic boot_slave_mode,
  input wire logic load_done,
  input wire logic load_stop
);
  // ****************************************************************
  // port relations
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_sclk_cs; flash_sclk |-> !flash_cs_n; endproperty
  a_sclk_cs: assert property (p_sclk_cs) else $error("clock without select");
  property p_sclk_half; $rose(flash_sclk) |-> flash_sclk [*4] ##1 !flash_sclk; endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("clock high phase wrong");
  property p_cmd_start; $fell(flash_cs_n) |-> !flash_lane0_oe_n && !flash_lane0_o ##[8:10] flash_lane0_o; endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("command start wrong");
  property p_slave_quiet;
    boot_slave_mode |-> flash_cs_n && !flash_sclk && flash_lane0_oe_n && flash_lane2_oe_n && flash_lane3_oe_n;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("flash touched in slave boot");
  property p_cs_start; $rose(boot_flash_mode) |-> ##[0:2] !flash_cs_n; endproperty
  a_cs_start: assert property (p_cs_start) else $error("flash boot without select");
  property p_lane1_free; flash_lane1_boot_strap_oe_n; endproperty
  a_lane1_free: assert property (p_lane1_free) else $error("strap lane driven");
  property p_cs_release; $rose(flash_cs_n) |-> load_stop; endproperty
  a_cs_release: assert property (p_cs_release) else $error("select dropped early");
  property p_done_idle; load_done |-> flash_cs_n && !flash_sclk; endproperty
  a_done_idle: assert property (p_done_idle) else $error("link busy after done");
endmodule
bind qbl_boot_loader qbl_boot_loader_checker i_qbl_boot_loader_checker (
  .core_clk, .reset_n, .flash_cs_n, .flash_sclk, .flash_lane0_o, .flash_lane0_oe_n,
  .flash_lane1_boot_strap_oe_n, .flash_lane2_oe_n, .flash_lane3_oe_n,
  .boot_flash_mode, .boot_slave_mode, .load_done, .load_stop
);
`default_nettype wire

// >>> qbl_fifo.sv
// synchronous fifo with a registered output stage
// assumes both sides sit on the same clock
`timescale 1ns/1ps
`default_nettype none
module qbl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready = !full;
  assign push = in_valid && !full;
  // refill the output register whenever it is free or being taken
  assign pop = !empty && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_q[rd_q[AW-1:0]];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> qbl_flash_model.sv
// behavioural quad flash that answers one read from address zero
// assumes mode 0 clocking from the loader and a free-running core clock
`timescale 1ns/1ps
`default_nettype none
module qbl_flash_model (
  input wire logic clk,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic lane0,
  output logic [3:0] dq,
  output logic dq_en,
  output logic [31:0] hdr,
  output int cmds
);
  // ****************************************************************
  // array and serial state
  // ****************************************************************
  logic qe = 1'b1;
  logic [7:0] mem [0:255];
  logic [7:0] b;
  int bits;
  initial begin
    cmds = 0;
    dq = 4'h0;
    dq_en = 1'b0;
    for (int i = 0; i < 256; i++) begin
      b = 8'(i) ^ 8'h5a;
      mem[i] = {b[3:0], b[7:4]};
    end
  end
  always @(negedge cs_n) begin
    bits = 0;
    cmds++;
  end
  always @(posedge cs_n) dq_en = 1'b0;
  always @(posedge sclk) if (!cs_n && bits < 32) hdr = {hdr[30:0], lane0};
  // address advances every two nibbles with select held
  always @(negedge sclk) if (!cs_n) begin
    bits++;
    if (bits >= 40 && qe) begin
      dq_en = 1'b1;
      b = mem[8'((bits - 40) / 2)];
      dq = bits[0] ? b[3:0] : b[7:4];
    end
  end
  // released lanes never hold their last value
  always @(posedge clk) if (!dq_en) dq <= ~dq;
endmodule
`default_nettype wire

// >>> qbl_pkg.sv
// constants and types shared by the quad flash boot loader files
// assumes one 100 MHz core clock and an active-low asynchronous reset
//
// How it works
// RULE1: default boot drives flash pins, generates clock
// RULE2: send read command, then address zero
// RULE3: strap high selects slave boot, flash idle
// RULE4: strap low or floating selects flash boot
// RULE5: strap sampled before lane1 carries data
// RULE6: first nibble low bits, second high
// RULE7: programmer stores nibble-swapped image if needed
// RULE8: programmer sets flash quad-enable bit
// RULE9: loading starts only after reset release
// RULE10: select held, addresses increment, one command
package qbl_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned QBL_CORE_CLK_HZ = 100_000_000;
  // half period of the flash clock in core cycles (12.5 MHz link)
  localparam logic [3:0] QBL_SCLK_HALF = 4'h4;
  // strap settle after reset release, covers the two-flop synchroniser
  localparam int unsigned QBL_STRAP_SETTLE_NS = 100;
  localparam logic [4:0] QBL_STRAP_CYCLES =
    5'((QBL_STRAP_SETTLE_NS * (QBL_CORE_CLK_HZ / 1_000_000) + 999) / 1000);

  // ****************************************************************
  // flash command sequence
  // ****************************************************************
  // quad output read; data on four lanes after the dummy clocks
  localparam logic [7:0] QBL_READ_CMD = 8'h6b;
  localparam logic [23:0] QBL_START_ADDR = 24'h000000;
  localparam logic [5:0] QBL_HDR_BITS = 6'h20;
  localparam logic [5:0] QBL_DUMMY_CLKS = 6'h08;

  // ****************************************************************
  // buffering
  // ****************************************************************
  localparam int unsigned QBL_FIFO_WIDTH = 8;
  localparam int unsigned QBL_FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    QBL_ST_STRAP,
    QBL_ST_SLAVE,
    QBL_ST_HDR,
    QBL_ST_DUMMY,
    QBL_ST_DATA,
    QBL_ST_DONE
  } qbl_state_t;

endpackage

// >>> qbl_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module qbl_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the quad flash boot loader
// assumes the flash model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************************************
  // harness
  // ****************************************************************
  logic core_clk = 1'b0, reset_n = 1'b0, load_stop = 1'b0, image_ready = 1'b0, strap = 1'b0;
  logic flash_cs_n, flash_sclk, boot_flash_mode, boot_slave_mode, load_done, image_valid, dq_en;
  logic flash_lane0_o, flash_lane0_oe_n, flash_lane1_boot_strap_o, flash_lane1_boot_strap_oe_n;
  logic flash_lane2_o, flash_lane2_oe_n, flash_lane3_o, flash_lane3_oe_n;
  logic [7:0] image_data;
  logic [3:0] dq;
  logic [31:0] hdr;
  int cmds, err_count = 0, total_checks = 0;
  // the strap is a pull, so it shows on lane1 whenever the flash lets go
  wire flash_lane0_i = flash_lane0_oe_n ? dq[0] : flash_lane0_o;
  wire flash_lane1_boot_strap_i = dq_en ? dq[1] : strap;
  wire flash_lane2_i = flash_lane2_oe_n ? dq[2] : flash_lane2_o;
  wire flash_lane3_i = flash_lane3_oe_n ? dq[3] : flash_lane3_o;
  always #5 core_clk = ~core_clk;
  qbl_boot_loader i_qbl_boot_loader (
    .core_clk, .reset_n, .flash_cs_n, .flash_sclk,
    .flash_lane0_i, .flash_lane0_o, .flash_lane0_oe_n,
    .flash_lane1_boot_strap_i, .flash_lane1_boot_strap_o, .flash_lane1_boot_strap_oe_n,
    .flash_lane2_i, .flash_lane2_o, .flash_lane2_oe_n,
    .flash_lane3_i, .flash_lane3_o, .flash_lane3_oe_n,
    .boot_flash_mode, .boot_slave_mode, .load_done,
    .load_stop, .image_valid, .image_ready, .image_data
  );
  qbl_flash_model i_qbl_flash_model (
    .clk(core_clk), .cs_n(flash_cs_n), .sclk(flash_sclk), .lane0(flash_lane0_i),
    .dq(dq), .dq_en(dq_en), .hdr(hdr), .cmds(cmds)
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(negedge core_clk);
    chk("wait", 32'(v), 32'(s));
    if (s !== v) summarize();
  endtask
  task automatic boot(input logic s);
    @(posedge core_clk);
    reset_n <= 1'b0;
    strap <= s;
    load_stop <= 1'b0;
    image_ready <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // sink stalls until the fifo refuses, then drains and stops mid image
  task automatic t_flash();
    int c0;
    int n;
    c0 = cmds;
    n = 0;
    boot(1'b0);
    wait_for(boot_flash_mode, 1'b1, 40);
    wait_for(flash_cs_n, 1'b0, 10);
    chk("hold lanes", 32'h3, 32'({flash_lane2_o, flash_lane3_o}));
    chk("strap lane out", 32'h0, 32'(flash_lane1_boot_strap_o));
    repeat (1200) @(posedge core_clk);
    @(negedge core_clk);
    chk("header", 32'h6b000000, hdr);
    chk("stall clock", 32'h0, 32'(flash_sclk));
    for (int i = 0; i < 4000; i++) begin
      @(posedge core_clk);
      image_ready <= 1'b1;
      load_stop <= (n >= 48);
      @(negedge core_clk);
      if (image_valid === 1'b1) begin
        chk("byte", 32'(8'(n) ^ 8'h5a), 32'(image_data));
        n++;
      end
      if (load_done === 1'b1 && image_valid !== 1'b1) break;
    end
    wait_for(load_done, 1'b1, 1);
    chk("select after stop", 32'h1, 32'(flash_cs_n));
    chk("commands", 32'(c0 + 1), 32'(cmds));
    chk("slave flag", 32'h0, 32'(boot_slave_mode));
  endtask
  task automatic t_slave();
    int c0;
    c0 = cmds;
    boot(1'b1);
    repeat (60) @(posedge core_clk);
    @(negedge core_clk);
    chk("slave flag", 32'h1, 32'(boot_slave_mode));
    chk("flash flag", 32'h0, 32'(boot_flash_mode));
    chk("select", 32'h1, 32'(flash_cs_n));
    chk("lanes released", 32'hf, 32'({flash_lane0_oe_n, flash_lane1_boot_strap_oe_n, flash_lane2_oe_n, flash_lane3_oe_n}));
    chk("commands", 32'(c0), 32'(cmds));
  endtask
  initial begin
    t_flash();
    boot(1'b0);
    wait_for(flash_cs_n, 1'b0, 60);
    t_slave();
    t_flash();
    summarize();
  end
endmodule
`default_nettype wire
